// ==== include/otfr_pkg.sv ====
// Constants and types for the over-temperature fault response controller
package otfr_pkg;
  localparam logic [7:0] CMD_OT_ACTION = 8'h50;
  localparam logic [7:0] CMD_TIME_UNIT = 8'hD2;
  localparam logic [7:0] OT_ACTION_RESET = 8'h80;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;
  localparam int RESP_MSB = 7;
  localparam int RESP_LSB = 6;
  localparam int RETRY_MSB = 5;
  localparam int RETRY_LSB = 3;
  localparam int DELAY_MSB = 2;
  localparam int DELAY_LSB = 0;
  localparam logic [1:0] RESP_IGNORE = 2'h0;
  localparam logic [1:0] RESP_RIDE = 2'h1;
  localparam logic [1:0] RESP_DISABLE_RETRY = 2'h2;
  localparam logic [1:0] RESP_LATCH = 2'h3;
  localparam logic [2:0] RETRY_NONE = 3'h0;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;
  localparam int UNIT_W = 16;
  localparam int UNITCNT_W = 8;
  localparam logic [UNIT_W-1:0] UNIT_CYCLES_MIN = 16'h0001;

  typedef enum logic [2:0] {
    ST_RUN,
    ST_RIDE,
    ST_HOLDOFF,
    ST_ATTEMPT,
    ST_LATCHED
  } otfr_state_t;
endpackage : otfr_pkg

// ==== include/otfr_timer_if.sv ====
// Start/expiry link between the response sequencer and its delay timer
`timescale 1ns/1ps
interface otfr_timer_if;
  logic start;
  logic stop;
  logic [2:0] exponent;
  logic [otfr_pkg::UNIT_W-1:0] unit_cycles;
  logic done;

  modport ctrl (output start, output stop, output exponent, output unit_cycles, input done);
  modport timer (input start, input stop, input exponent, input unit_cycles, output done);
endinterface : otfr_timer_if

// ==== verilog/otfr_timer.sv ====
// Delay timer counting two-to-the-field delay units
`timescale 1ns/1ps
module otfr_timer
(
  input wire logic clock,
  input wire logic arst_n,
  otfr_timer_if.timer tif
);
  import otfr_pkg::*;

  logic [UNIT_W-1:0] pre_reg, pre_next;
  logic [UNITCNT_W-1:0] units_reg, units_next;
  logic run_reg, run_next;
  logic done_reg, done_next;
  logic [UNIT_W-1:0] unit_len;
  logic unit_tick;

  // Units for a delay field value: 1, 2, 4 ... 128
  function automatic logic [UNITCNT_W-1:0] units_for(input logic [2:0] e);
    units_for = UNITCNT_W'(1) << e;
  endfunction : units_for

  assign unit_len = (tif.unit_cycles == '0) ? UNIT_CYCLES_MIN : tif.unit_cycles;
  assign unit_tick = run_reg && (pre_reg == unit_len - UNIT_CYCLES_MIN);
  assign tif.done = done_reg;

  always_comb
  begin
    pre_next = pre_reg;
    units_next = units_reg;
    run_next = run_reg;
    done_next = 1'b0;
    if (tif.start || tif.stop)
    begin
      pre_next = '0;
      // RULE11 power-of-two units
      units_next = units_for(tif.exponent);
      run_next = tif.start;
    end
    else if (unit_tick)
    begin
      pre_next = '0;
      if (units_reg == UNITCNT_W'(1))
      begin
        run_next = 1'b0;
        done_next = 1'b1;
      end
      else
      begin
        units_next = units_reg - UNITCNT_W'(1);
      end
    end
    else if (run_reg)
    begin
      pre_next = pre_reg + UNIT_W'(1);
    end
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pre_reg <= '0;
      units_reg <= '0;
      run_reg <= 1'b0;
      done_reg <= 1'b0;
    end
    else
    begin
      pre_reg <= pre_next;
      units_reg <= units_next;
      run_reg <= run_next;
      done_reg <= done_next;
    end
  end
endmodule : otfr_timer

// ==== verilog/otfr_ctrl.sv ====
// Over-temperature fault response sequencer with its action register
// Overview of operation
// RULE1: Response 00 ignores the fault; output keeps running uninterrupted.
// RULE2: Response 01 runs on for the delay, then applies retries if fault persists.
// RULE3: Response 10 disables output at once, then follows the retry field.
// RULE4: Response 11 latches off until bit clear, clear-faults command or reset.
// RULE5: An off-then-on command on the on/off control also clears the fault.
// RULE6: Retry field 000 makes no restart; output stays off until cleared.
// RULE7: Retry codes 1 to 3 give that many restarts, then latch off.
// RULE8: Starts of successive restart attempts are spaced by the delay.
// RULE9: Retry codes 4 to 6 give that many restarts, then latch off.
// RULE10: Retry code 111 retries without limit until commanded off.
// RULE11: Delay field n means two to the n delay time units.
// RULE12: Delay time unit length comes from the separate timing register.
// RULE13: Clearing the fault resets attempt counter and delay timer.
// RULE14: Host writes the action byte before enabling the output.
`timescale 1ns/1ps
module otfr_ctrl
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic cmd_strobe,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic [7:0] cmd_wdata,
  output logic [7:0] cmd_rdata,
  output logic cmd_hit,
  input wire logic [otfr_pkg::UNIT_W-1:0] time_unit_cycles,
  input wire logic ot_fault,
  input wire logic fault_bit_clear,
  input wire logic clear_faults_cmd,
  input wire logic reset_cmd,
  input wire logic output_on_cmd,
  output logic output_enable,
  output logic fault_off,
  output logic [2:0] attempt_count
);
  import otfr_pkg::*;

  otfr_timer_if tif ();

  otfr_timer u_timer (
    .clock (clock),
    .arst_n (arst_n),
    .tif (tif)
  );

  logic [7:0] action_reg, action_next;
  logic [7:0] rdata_reg, rdata_next;
  otfr_state_t state_reg, state_next;
  logic [2:0] count_reg, count_next;
  logic on_prev_reg;
  logic en_reg, en_next;
  logic [1:0] resp;
  logic [2:0] retries;
  logic clear_evt;
  logic start_t;

  // True while another restart attempt is allowed
  function automatic logic may_retry(input logic [2:0] limit, input logic [2:0] done_cnt);
    may_retry = (limit == RETRY_FOREVER) || (done_cnt < limit);
  endfunction : may_retry

  // Attempt count after one more restart; unlimited retries leave it unchanged
  function automatic logic [2:0] bumped(input logic [2:0] limit, input logic [2:0] done_cnt);
    bumped = (limit == RETRY_FOREVER) ? done_cnt : done_cnt + 3'h1;
  endfunction : bumped

  assign resp = action_reg[RESP_MSB:RESP_LSB];
  assign retries = action_reg[RETRY_MSB:RETRY_LSB];
  assign cmd_hit = cmd_strobe && (cmd_code == CMD_OT_ACTION);
  assign cmd_rdata = rdata_reg;
  assign output_enable = en_reg;
  assign fault_off = (state_reg == ST_LATCHED);
  assign attempt_count = count_reg;

  // RULE4 clear sources
  // RULE5 off then on
  assign clear_evt = fault_bit_clear || clear_faults_cmd || reset_cmd
                     || (output_on_cmd && !on_prev_reg);

  // RULE12 unit length
  assign tif.unit_cycles = time_unit_cycles;
  assign tif.exponent = action_reg[DELAY_MSB:DELAY_LSB];
  assign tif.start = start_t;
  // RULE13 timer reset on clear
  assign tif.stop = clear_evt;

  always_comb
  begin
    action_next = action_reg;
    rdata_next = rdata_reg;
    if (cmd_strobe && cmd_write && cmd_code == CMD_OT_ACTION)
    begin
      action_next = cmd_wdata;
    end
    if (cmd_strobe && !cmd_write)
    begin
      rdata_next = (cmd_code == CMD_OT_ACTION) ? action_reg : READ_UNMAPPED;
    end
  end

  always_comb
  begin
    state_next = state_reg;
    count_next = count_reg;
    start_t = 1'b0;
    if (clear_evt)
    begin
      // RULE13 fresh sequence
      state_next = ST_RUN;
      count_next = '0;
    end
    else
    begin
      case (state_reg)
        ST_RUN:
        begin
          if (ot_fault)
          begin
            case (resp)
              // RULE1 ignore fault
              RESP_IGNORE: state_next = ST_RUN;
              RESP_RIDE:
              begin
                // RULE2 ride-through delay
                state_next = ST_RIDE;
                start_t = 1'b1;
              end
              RESP_DISABLE_RETRY:
              begin
                // RULE3 disable then retry
                // RULE6 no retry latches
                state_next = (retries == RETRY_NONE) ? ST_LATCHED : ST_HOLDOFF;
                start_t = (retries != RETRY_NONE);
              end
              default: state_next = ST_LATCHED;
            endcase
          end
        end
        ST_RIDE:
        begin
          if (!ot_fault)
          begin
            state_next = ST_RUN;
            start_t = 1'b0;
          end
          else if (tif.done)
          begin
            // RULE2 apply retry field
            state_next = (retries == RETRY_NONE) ? ST_LATCHED : ST_HOLDOFF;
            start_t = (retries != RETRY_NONE);
          end
        end
        ST_HOLDOFF:
        begin
          if (tif.done)
          begin
            // RULE7 bounded attempts
            // RULE9 bounded attempts
            // RULE10 unlimited attempts
            if (may_retry(retries, count_reg))
            begin
              state_next = ST_ATTEMPT;
              start_t = 1'b1;
              count_next = bumped(retries, count_reg);
            end
            else
            begin
              state_next = ST_LATCHED;
            end
          end
        end
        ST_ATTEMPT:
        begin
          // RULE8 attempt spacing kept by running timer
          if (ot_fault && tif.done)
          begin
            // Failure seen as the window closes; the expiry must not be lost
            if (may_retry(retries, count_reg))
            begin
              state_next = ST_ATTEMPT;
              start_t = 1'b1;
              count_next = bumped(retries, count_reg);
            end
            else
            begin
              state_next = ST_LATCHED;
            end
          end
          else if (ot_fault)
          begin
            state_next = ST_HOLDOFF;
          end
          else if (tif.done)
          begin
            state_next = ST_RUN;
            count_next = '0;
          end
        end
        ST_LATCHED: state_next = ST_LATCHED;
        default: state_next = ST_RUN;
      endcase
    end
  end

  always_comb
  begin
    en_next = output_on_cmd
              && (state_next == ST_RUN || state_next == ST_RIDE || state_next == ST_ATTEMPT);
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      action_reg <= OT_ACTION_RESET;
      rdata_reg <= READ_UNMAPPED;
      state_reg <= ST_RUN;
      count_reg <= '0;
      on_prev_reg <= 1'b0;
      en_reg <= 1'b0;
    end
    else
    begin
      action_reg <= action_next;
      rdata_reg <= rdata_next;
      state_reg <= state_next;
      count_reg <= count_next;
      on_prev_reg <= output_on_cmd;
      en_reg <= en_next;
    end
  end
endmodule : otfr_ctrl

// ==== testbench/otfr_ctrl_asserts.sv ====
// Port assertions for the fault response controller
`timescale 1ns/1ps
module otfr_ctrl_asserts
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic cmd_strobe,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic [7:0] cmd_wdata,
  input wire logic [7:0] cmd_rdata,
  input wire logic cmd_hit,
  input wire logic ot_fault,
  input wire logic fault_bit_clear,
  input wire logic clear_faults_cmd,
  input wire logic reset_cmd,
  input wire logic output_on_cmd,
  input wire logic output_enable,
  input wire logic fault_off,
  input wire logic [2:0] attempt_count
);
  import otfr_pkg::*;
  logic [7:0] act_reg;
  logic [7:0] act_next;
  always_comb
  begin
    act_next = act_reg;
    if (cmd_strobe && cmd_write && cmd_code == CMD_OT_ACTION)
      act_next = cmd_wdata;
  end
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      act_reg <= OT_ACTION_RESET;
    else
      act_reg <= act_next;
  end
  default clocking @(posedge clock);
  endclocking
  default disable iff (!arst_n);
  sequence s_rise;
    $rose(ot_fault) && !fault_off;
  endsequence
  sequence s_clear;
    clear_faults_cmd || fault_bit_clear || reset_cmd;
  endsequence
  chk_read_back:
    assert property (cmd_strobe && !cmd_write |=>
      cmd_rdata == ($past(cmd_code) == CMD_OT_ACTION ? act_reg : READ_UNMAPPED))
    else $error("read data");
  chk_hit_decode:
    assert property (cmd_hit == (cmd_strobe && cmd_code == CMD_OT_ACTION))
    else $error("hit decode");
  chk_ride_on:
    assert property (s_rise ##0 act_reg[RESP_MSB:RESP_LSB] == RESP_RIDE && output_on_cmd
      |=> output_enable)
    else $error("ride off");
  chk_ignore_runs:
    assert property (s_rise ##0 act_reg[RESP_MSB:RESP_LSB] == RESP_IGNORE |=> !fault_off [*8])
    else $error("ignore off");
  chk_disable_fast:
    assert property (s_rise ##0 act_reg[RESP_MSB:RESP_LSB] == RESP_DISABLE_RETRY
      |-> ##[1:2] !output_enable)
    else $error("no disable");
  chk_latch_fast:
    assert property (s_rise ##0 act_reg[RESP_MSB:RESP_LSB] == RESP_LATCH |-> ##[1:2] fault_off)
    else $error("no latch");
  chk_clear_run:
    assert property (s_clear |=> !fault_off && attempt_count == 3'h0)
    else $error("clear");
  chk_on_edge:
    assert property ($rose(output_on_cmd) |=> !fault_off)
    else $error("on edge");
  chk_latched_off:
    assert property (fault_off [*2] |-> !output_enable)
    else $error("latched on");
  chk_count_cap:
    assert property (attempt_count <= act_reg[RETRY_MSB:RETRY_LSB])
    else $error("count");
endmodule : otfr_ctrl_asserts
bind otfr_ctrl otfr_ctrl_asserts u_chk (.clock(clock), .arst_n(arst_n),
  .cmd_strobe(cmd_strobe), .cmd_write(cmd_write), .cmd_code(cmd_code),
  .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .cmd_hit(cmd_hit), .ot_fault(ot_fault),
  .fault_bit_clear(fault_bit_clear), .clear_faults_cmd(clear_faults_cmd),
  .reset_cmd(reset_cmd), .output_on_cmd(output_on_cmd),
  .output_enable(output_enable), .fault_off(fault_off), .attempt_count(attempt_count));

// ==== testbench/otfr_host.sv ====
// Host model issuing one-byte command accesses
`timescale 1ns/1ps
module otfr_host (
  input wire logic clock,
  output logic cmd_strobe,
  output logic cmd_write,
  output logic [7:0] cmd_code,
  output logic [7:0] cmd_wdata,
  input wire logic [7:0] cmd_rdata
);
  initial
  begin
    cmd_strobe = 1'b0;
    cmd_write = 1'b0;
    cmd_code = 8'h00;
    cmd_wdata = 8'h00;
  end
  task automatic access(input logic w, input logic [7:0] c, input logic [7:0] v,
                        output logic [7:0] r);
    @(posedge clock);
    cmd_strobe <= 1'b1;
    cmd_write <= w;
    cmd_code <= c;
    cmd_wdata <= v;
    @(posedge clock);
    cmd_strobe <= 1'b0;
    cmd_code <= ~c;
    cmd_wdata <= ~v;
    @(posedge clock);
    r = cmd_rdata;
  endtask : access
endmodule : otfr_host

// ==== testbench/tb_otfr_ctrl.sv ====
// Bench driving command accesses and fault events
`timescale 1ns/1ps
module tb_otfr_ctrl;
  import otfr_pkg::*;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic ot_fault = 1'b0;
  logic on_cmd = 1'b0;
  logic [2:0] clr = 3'h0;
  logic stb, wr, oe, foff;
  logic [7:0] code, wd, rd, d;
  logic [2:0] cnt;
  int miscompares = 0;
  int samples_checked = 0;
  int cyc = 0;
  int n0, n3, n5;
  logic [15:0] unit = 16'h0002;
  otfr_host host (.clock(clock), .cmd_strobe(stb), .cmd_write(wr), .cmd_code(code),
    .cmd_wdata(wd), .cmd_rdata(rd));
  otfr_ctrl uut (.clock(clock), .arst_n(arst_n), .cmd_strobe(stb), .cmd_write(wr),
    .cmd_code(code), .cmd_wdata(wd), .cmd_rdata(rd), .cmd_hit(),
    .time_unit_cycles(unit), .ot_fault(ot_fault), .fault_bit_clear(clr[0]),
    .clear_faults_cmd(clr[1]), .reset_cmd(clr[2]), .output_on_cmd(on_cmd),
    .output_enable(oe), .fault_off(foff), .attempt_count(cnt));
  initial forever #12.5 clock = ~clock;
  task automatic end_sim;
    if (miscompares == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      miscompares++;
      end_sim();
    end
  end
  task automatic check(input logic [7:0] s, input logic [7:0] e);
    samples_checked++;
    if (s !== e)
    begin
      miscompares++;
      $display("mismatch at %0t: saw %h expected %h", $time, s, e);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick
  task automatic wait_off(output int n);
    n = 0;
    while (foff !== 1'b1 && n < 600)
    begin
      tick(1);
      n++;
    end
    check({7'h0, foff}, 8'h01);
  endtask : wait_off
  // Cycles from one restart attempt to the next
  task automatic gap(output int n);
    int i;
    i = 0;
    while (oe !== 1'b1 && i < 600)
    begin
      tick(1);
      i++;
    end
    n = 0;
    while (oe !== 1'b0 && n < 600)
    begin
      tick(1);
      n++;
    end
    while (oe !== 1'b1 && n < 600)
    begin
      tick(1);
      n++;
    end
  endtask : gap
  // Clear kind k: bit, command, reset, off then on
  task automatic clear(input int k);
    @(posedge clock) ot_fault <= 1'b0;
    @(posedge clock);
    if (k < 3)
      clr <= 3'h1 << k;
    else
      on_cmd <= 1'b0;
    @(posedge clock);
    clr <= 3'h0;
    on_cmd <= 1'b1;
    tick(2);
    check({4'h0, foff, cnt}, 8'h00);
  endtask : clear
  task automatic fault_on;
    @(posedge clock) ot_fault <= 1'b1;
  endtask : fault_on
  initial
  begin
    repeat (16) @(posedge clock);
    arst_n <= 1'b1;
    host.access(1'b0, CMD_OT_ACTION, 8'h00, d);
    check(d, OT_ACTION_RESET);
    host.access(1'b0, CMD_TIME_UNIT, 8'h00, d);
    check(d, READ_UNMAPPED);
    host.access(1'b1, CMD_OT_ACTION, 8'h00, d);
    @(posedge clock) on_cmd <= 1'b1;
    tick(3);
    fault_on();
    repeat (20)
    begin
      tick(1);
      check({7'h0, oe}, 8'h01);
    end
    for (int r = 0; r < 7; r++)
    begin
      clear(1);
      host.access(1'b1, CMD_OT_ACTION, {2'h2, r[2:0], 3'h0}, d);
      fault_on();
      wait_off(n0);
      check({5'h0, cnt}, {5'h0, r[2:0]});
    end
    for (int k = 0; k < 4; k++)
    begin
      clear(k);
      host.access(1'b1, CMD_OT_ACTION, 8'hC0, d);
      fault_on();
      wait_off(n0);
      check({7'h0, foff}, 8'h01);
    end
    clear(1);
    host.access(1'b1, CMD_OT_ACTION, 8'h40, d);
    fault_on();
    @(posedge clock) ot_fault <= 1'b0;
    repeat (20)
    begin
      tick(1);
      check({7'h0, oe}, 8'h01);
    end
    fault_on();
    wait_off(n0);
    clear(1);
    host.access(1'b1, CMD_OT_ACTION, 8'h43, d);
    fault_on();
    wait_off(n3);
    check(8'(n3 - n0), 8'h0E);
    clear(1);
    host.access(1'b1, CMD_OT_ACTION, 8'hB8, d);
    fault_on();
    n5 = 0;
    repeat (150)
    begin
      tick(1);
      n5 += int'(oe);
    end
    check({4'h0, foff, cnt}, 8'h00);
    check({7'h0, n5 > 6}, 8'h01);
    gap(n0);
    host.access(1'b1, CMD_OT_ACTION, 8'hBA, d);
    gap(n3);
    gap(n3);
    check(8'(n3 - n0), 8'h06);
    @(posedge clock) unit <= 16'h0005;
    gap(n5);
    gap(n5);
    check(8'(n5 - n3), 8'h0C);
    @(posedge clock) on_cmd <= 1'b0;
    tick(3);
    check({7'h0, oe}, 8'h00);
    end_sim();
  end
endmodule : tb_otfr_ctrl
